// ### verilog/imasb_pkg.sv
// package of the alarm status bank: map, field positions, reset values
// assumes 16-bit register words addressed by the fieldbus register number
package imasb_pkg;

    localparam int WORD_W = 16;
    localparam int NUM_INST = 2;
    localparam int NUM_WORDS = 7;

    // bank windows of the two module instances
    localparam logic [15:0] BASE_ONE = 16'h3989;
    localparam logic [15:0] BASE_TWO = 16'h4541;
    localparam logic [15:0] BANK_SPAN = 16'h001E;

    // instance one map; instance two sits at the same offset from its base
    localparam logic [15:0] GENERIC_ALARM_ONE_QUALITY = 16'h3993;
    localparam logic [15:0] GENERIC_ALARM_ONE_STATUS = 16'h3994;
    localparam logic [15:0] GENERIC_ALARM_TWO_QUALITY = 16'h3995;
    localparam logic [15:0] GENERIC_ALARM_TWO_STATUS = 16'h3996;
    localparam logic [15:0] CRADLE_ALARM_QUALITY = 16'h3997;
    localparam logic [15:0] CRADLE_DRAWER_ALARM_STATUS = 16'h3998;
    localparam logic [15:0] MOTOR_ALARM_QUALITY = 16'h3999;
    localparam logic [15:0] MOTOR_ALARM_STATUS = 16'h399A;
    localparam logic [15:0] OTHER_APP_ALARM_QUALITY = 16'h399B;
    localparam logic [15:0] OTHER_APP_ALARM_STATUS = 16'h399C;
    localparam logic [15:0] PREDEFINED_INPUT_ALARM_QUALITY = 16'h399D;
    localparam logic [15:0] PREDEFINED_INPUT_ALARM_STATUS = 16'h399E;
    localparam logic [15:0] DISCREPANCY_ALARM_QUALITY = 16'h399F;
    localparam logic [15:0] DISCREPANCY_ALARM_STATUS = 16'h39A0;
    localparam logic [15:0] ALARM_AREA_RESERVED = 16'h39A1;

    localparam logic [15:0] FIRST_PAIR = GENERIC_ALARM_ONE_QUALITY - BASE_ONE;
    localparam logic [15:0] LAST_PAIR = DISCREPANCY_ALARM_STATUS - BASE_ONE;

    // word index inside an instance
    localparam int W_GEN_ONE = 0;
    localparam int W_GEN_TWO = 1;
    localparam int W_CRADLE = 2;
    localparam int W_MOTOR = 3;
    localparam int W_OTHER = 4;
    localparam int W_PREDEF = 5;
    localparam int W_DISC = 6;

    // defined bits of each word, highest index first
    localparam logic [NUM_WORDS-1:0][15:0] WORD_MASK = {
        16'h000F, 16'h03FF, 16'h000B, 16'h0000, 16'h011F, 16'h003F, 16'h3F00
    };

    // field positions
    localparam int GEN_ONE_COUNTER_LSB = 8;
    localparam int GEN_ONE_TEMP_LSB = 11;
    localparam int GEN_TWO_USER_LSB = 0;
    localparam int CRADLE_POS_BIT = 0;
    localparam int CRADLE_OVERDUE_BIT = 1;
    localparam int CRADLE_LIMIT_BIT = 2;
    localparam int CRADLE_LIFE_BIT = 3;
    localparam int CRADLE_NEW_UNIT_BIT = 4;
    localparam int DRAWER_POS_BIT = 8;
    localparam int OTHER_NOT_CLOSED_BIT = 0;
    localparam int OTHER_NOT_OPENED_BIT = 1;
    localparam int OTHER_DUAL_BIT = 3;
    localparam int PREDEF_CONTACT_LSB = 0;
    localparam int PREDEF_PANEL_LSB = 6;
    localparam int DISC_LSB = 0;

    // reset and fill values
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] QUALITY_RESET = 16'h0000;
    localparam logic [15:0] RESERVED_READ = 16'h0000;

endpackage : imasb_pkg

// ### verilog/imasb_word.sv
// one alarm word with its quality word, sampled every clock
// assumes alarm and validity inputs are synchronous to ref_clk
`timescale 1ns/1ps

module imasb_word
    import imasb_pkg::*;
#(
    parameter logic [15:0] MASK = 16'h0000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // live alarm sources and their validity
    input wire logic [15:0] alarm_in,
    input wire logic [15:0] valid_in,
    // stored words
    output logic [15:0] status,
    output logic [15:0] quality
);

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] quality;
    } imasb_word_s;

    imasb_word_s cur;
    imasb_word_s next_cur;

    // reserved bits stay zero and are marked invalid
    always_comb begin
        next_cur = cur;
        next_cur.status = alarm_in & MASK;
        next_cur.quality = valid_in & MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur.status <= STATUS_RESET;
            cur.quality <= QUALITY_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign status = cur.status;
    assign quality = cur.quality;

    property p_status_tracks;
        @(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> status == ($past(alarm_in) & MASK);
    endproperty
    a_status_tracks: assert property (p_status_tracks)
        else $error("alarm word did not follow its source");

    property p_quality_tracks;
        @(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> quality == ($past(valid_in) & MASK);
    endproperty
    a_quality_tracks: assert property (p_quality_tracks)
        else $error("quality word did not follow validity");

    property p_reserved_clear;
        @(posedge ref_clk) disable iff (rst)
        ((status | quality) & ~MASK) == 16'h0000;
    endproperty
    a_reserved_clear: assert property (p_reserved_clear)
        else $error("reserved alarm bit set");

endmodule : imasb_word

// ### verilog/imasb_bank.sv
// alarm status bank of two expansion module instances, read by the master
// assumes one register access per clock, inputs synchronous to ref_clk
`timescale 1ns/1ps

module imasb_bank
    import imasb_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register access
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [15:0] addr,
    input wire logic [15:0] wr_data,
    output logic ack,
    output logic [15:0] rd_data,
    output logic addr_fault,
    output logic write_refused,
    // generic alarms, index is the module instance
    input wire logic [1:0][2:0] counter_overrun,
    input wire logic [1:0][2:0] temp_overrun,
    input wire logic [1:0][5:0] user_input_alarm,
    // cradle and drawer alarms
    input wire logic [1:0] cradle_position_mismatch,
    input wire logic [1:0] removal_overdue,
    input wire logic [1:0] operation_limit,
    input wire logic [1:0] cradle_life_low,
    input wire logic [1:0] new_trip_unit,
    input wire logic [1:0] drawer_position_mismatch,
    // other application alarms
    input wire logic [1:0] contactor_not_closed,
    input wire logic [1:0] contactor_not_opened,
    input wire logic [1:0] dual_setting_mismatch,
    // predefined input contacts
    input wire logic [1:0] earth_leakage_trip_contact,
    input wire logic [1:0] control_voltage_contact,
    input wire logic [1:0] surge_status_contact,
    input wire logic [1:0] surge_failure_contact,
    input wire logic [1:0] switch_position_indication_contact,
    input wire logic [1:0] fuse_blown_contact,
    input wire logic [1:0] emergency_stop,
    input wire logic [1:0] panel_temp_contact,
    input wire logic [1:0] ventilation_contact,
    input wire logic [1:0] door_contact,
    // discrepancy alarms
    input wire logic [1:0] hw_critical,
    input wire logic [1:0] fw_critical,
    input wire logic [1:0] hw_noncritical,
    input wire logic [1:0] fw_noncritical,
    // per-bit validity of every alarm word
    input wire logic [1:0][6:0][15:0] bit_valid
);

    typedef struct packed {
        logic ack;
        logic [15:0] data;
        logic addr_fault;
        logic write_refused;
    } imasb_bank_s;

    imasb_bank_s cur;
    imasb_bank_s next_cur;

    logic [1:0][6:0][15:0] alarm_src;
    logic [1:0][6:0][15:0] status_word;
    logic [1:0][6:0][15:0] quality_word;

    // true when the address falls in the window starting at base
    function automatic logic in_bank(
        input logic [15:0] a,
        input logic [15:0] base
    );
        return (a >= base) && (a < base + BANK_SPAN);
    endfunction : in_bank

    // build the live alarm words of both instances
    always_comb begin
        alarm_src = '0;
        for (int i = 0; i < NUM_INST; i++) begin
            alarm_src[i][W_GEN_ONE][GEN_ONE_COUNTER_LSB +: 3] =
                counter_overrun[i];
            alarm_src[i][W_GEN_ONE][GEN_ONE_TEMP_LSB +: 3] =
                temp_overrun[i];
            alarm_src[i][W_GEN_TWO][GEN_TWO_USER_LSB +: 6] =
                user_input_alarm[i];
            alarm_src[i][W_CRADLE][CRADLE_POS_BIT] =
                cradle_position_mismatch[i];
            alarm_src[i][W_CRADLE][CRADLE_OVERDUE_BIT] =
                removal_overdue[i];
            alarm_src[i][W_CRADLE][CRADLE_LIMIT_BIT] =
                operation_limit[i];
            alarm_src[i][W_CRADLE][CRADLE_LIFE_BIT] =
                cradle_life_low[i];
            alarm_src[i][W_CRADLE][CRADLE_NEW_UNIT_BIT] =
                new_trip_unit[i];
            alarm_src[i][W_CRADLE][DRAWER_POS_BIT] =
                drawer_position_mismatch[i];
            alarm_src[i][W_MOTOR] = 16'h0000;
            alarm_src[i][W_OTHER][OTHER_NOT_CLOSED_BIT] =
                contactor_not_closed[i];
            alarm_src[i][W_OTHER][OTHER_NOT_OPENED_BIT] =
                contactor_not_opened[i];
            alarm_src[i][W_OTHER][OTHER_DUAL_BIT] =
                dual_setting_mismatch[i];
            alarm_src[i][W_PREDEF][PREDEF_CONTACT_LSB +: 6] = {
                fuse_blown_contact[i],
                switch_position_indication_contact[i],
                surge_failure_contact[i],
                surge_status_contact[i],
                control_voltage_contact[i],
                earth_leakage_trip_contact[i]
            };
            alarm_src[i][W_PREDEF][PREDEF_PANEL_LSB +: 4] = {
                door_contact[i],
                ventilation_contact[i],
                panel_temp_contact[i],
                emergency_stop[i]
            };
            alarm_src[i][W_DISC][DISC_LSB +: 4] = {
                fw_noncritical[i],
                hw_noncritical[i],
                fw_critical[i],
                hw_critical[i]
            };
        end
    end

    // one alarm word and quality word per group and instance
    for (genvar gi = 0; gi < NUM_INST; gi++) begin : g_inst
        for (genvar gw = 0; gw < NUM_WORDS; gw++) begin : g_word
            imasb_word #(
                .MASK(WORD_MASK[gw])
            ) u_word (
                .ref_clk(ref_clk),
                .rst(rst),
                .alarm_in(alarm_src[gi][gw]),
                .valid_in(bit_valid[gi][gw]),
                .status(status_word[gi][gw]),
                .quality(quality_word[gi][gw])
            );
        end
    end

    // register access: answer one cycle after the request
    always_comb begin
        logic hit;
        logic inst;
        logic [15:0] rel;
        logic [15:0] pair;
        logic [2:0] widx;
        hit = 1'b0;
        inst = 1'b0;
        rel = 16'h0000;
        pair = 16'h0000;
        widx = 3'h0;
        next_cur = cur;
        next_cur.ack = rd_en | wr_en;
        next_cur.addr_fault = 1'b0;
        next_cur.write_refused = 1'b0;
        if (in_bank(addr, BASE_ONE)) begin
            hit = 1'b1;
            inst = 1'b0;
            rel = addr - BASE_ONE;
        end else if (in_bank(addr, BASE_TWO)) begin
            hit = 1'b1;
            inst = 1'b1;
            rel = addr - BASE_TWO;
        end
        pair = rel - FIRST_PAIR;
        widx = pair[3:1];
        if (wr_en) begin
            // stored words have no write path at all
            next_cur.write_refused = 1'b1;
            next_cur.addr_fault = !hit;
            next_cur.data = RESERVED_READ;
        end else if (rd_en) begin
            if (!hit) begin
                next_cur.addr_fault = 1'b1;
                next_cur.data = RESERVED_READ;
            end else if (rel >= FIRST_PAIR && rel <= LAST_PAIR) begin
                if (pair[0]) begin
                    next_cur.data = status_word[inst][widx];
                end else begin
                    next_cur.data = quality_word[inst][widx];
                end
            end else begin
                next_cur.data = RESERVED_READ;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur.ack <= 1'b0;
            cur.data <= RESERVED_READ;
            cur.addr_fault <= 1'b0;
            cur.write_refused <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign ack = cur.ack;
    assign rd_data = cur.data;
    assign addr_fault = cur.addr_fault;
    assign write_refused = cur.write_refused;

    property p_ack_one_cycle;
        @(posedge ref_clk) disable iff (rst)
        (rd_en | wr_en) |=> ack ##1 (ack == $past(rd_en | wr_en));
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("access not answered in one cycle");

    property p_write_refused;
        @(posedge ref_clk) disable iff (rst)
        wr_en |=> write_refused && rd_data == 16'h0000;
    endproperty
    a_write_refused: assert property (p_write_refused)
        else $error("write to read-only bank not refused");

    property p_write_no_effect;
        @(posedge ref_clk) disable iff (rst)
        wr_en && $stable(alarm_src) && $stable(bit_valid) |=>
            $stable(status_word) && $stable(quality_word);
    endproperty
    a_write_no_effect: assert property (p_write_no_effect)
        else $error("write altered a stored alarm word");

    property p_read_gen_one;
        @(posedge ref_clk) disable iff (rst)
        rd_en && !wr_en && addr == GENERIC_ALARM_ONE_STATUS |=>
            rd_data == $past(status_word[0][W_GEN_ONE]) && ack;
    endproperty
    a_read_gen_one: assert property (p_read_gen_one)
        else $error("generic word one read wrong");

    property p_counter_to_read;
        @(posedge ref_clk) disable iff (rst)
        counter_overrun[0][0] ##1 rd_en && !wr_en &&
            addr == GENERIC_ALARM_ONE_STATUS
            |=> rd_data[GEN_ONE_COUNTER_LSB];
    endproperty
    a_counter_to_read: assert property (p_counter_to_read)
        else $error("counter overrun not seen in read");

    property p_read_quality;
        @(posedge ref_clk) disable iff (rst)
        rd_en && !wr_en && addr == CRADLE_ALARM_QUALITY |=>
            rd_data == $past(quality_word[0][W_CRADLE]);
    endproperty
    a_read_quality: assert property (p_read_quality)
        else $error("quality word read wrong");

    property p_second_inst;
        @(posedge ref_clk) disable iff (rst)
        rd_en && !wr_en &&
            addr == BASE_TWO + (DISCREPANCY_ALARM_STATUS - BASE_ONE) |=>
            rd_data == $past(status_word[1][W_DISC]) && !addr_fault;
    endproperty
    a_second_inst: assert property (p_second_inst)
        else $error("second instance discrepancy word read wrong");

    property p_motor_zero;
        @(posedge ref_clk) disable iff (rst)
        rd_en && !wr_en && addr == MOTOR_ALARM_STATUS |=>
            rd_data == 16'h0000;
    endproperty
    a_motor_zero: assert property (p_motor_zero)
        else $error("motor alarm word not zero");

    property p_bad_addr;
        @(posedge ref_clk) disable iff (rst)
        rd_en && !wr_en && !in_bank(addr, BASE_ONE) &&
            !in_bank(addr, BASE_TWO) |=> addr_fault && rd_data == 16'h0000;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("unmapped read not faulted");

    property p_write_fault;
        @(posedge ref_clk) disable iff (rst)
        wr_en && !in_bank(addr, BASE_ONE) && !in_bank(addr, BASE_TWO) |=>
            addr_fault && write_refused && ack;
    endproperty
    a_write_fault: assert property (p_write_fault)
        else $error("unmapped write not faulted");

    property p_idle_quiet;
        @(posedge ref_clk) disable iff (rst)
        !(rd_en || wr_en) |=> !ack && !addr_fault && !write_refused;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("answer without a request");

    property p_read_hold;
        @(posedge ref_clk) disable iff (rst)
        !(rd_en || wr_en) |=> $stable(rd_data);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data changed without a request");

    property p_reserved_read;
        @(posedge ref_clk) disable iff (rst)
        rd_en && !wr_en && addr == ALARM_AREA_RESERVED |=>
            ack && !addr_fault && rd_data == 16'h0000;
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("reserved area read not zero");

    property p_second_quality;
        @(posedge ref_clk) disable iff (rst)
        rd_en && !wr_en &&
            addr == BASE_TWO + (CRADLE_ALARM_QUALITY - BASE_ONE) |=>
            rd_data == $past(quality_word[1][W_CRADLE]);
    endproperty
    a_second_quality: assert property (p_second_quality)
        else $error("second instance quality word read wrong");

    property p_read_drawer;
        @(posedge ref_clk) disable iff (rst)
        drawer_position_mismatch[0] ##1 rd_en && !wr_en &&
            addr == CRADLE_DRAWER_ALARM_STATUS |=> rd_data[DRAWER_POS_BIT];
    endproperty
    a_read_drawer: assert property (p_read_drawer)
        else $error("drawer mismatch not seen in read");

    property p_read_predef;
        @(posedge ref_clk) disable iff (rst)
        earth_leakage_trip_contact[0] ##1 rd_en && !wr_en &&
            addr == PREDEFINED_INPUT_ALARM_STATUS
            |=> rd_data[PREDEF_CONTACT_LSB];
    endproperty
    a_read_predef: assert property (p_read_predef)
        else $error("earth leakage contact not seen in read");

endmodule : imasb_bank

// ### verification/imasb_master.sv
// fieldbus master model that polls the alarm status bank one word at a time
// assumes the bank answers with ack one cycle after it takes a request
`timescale 1ns/1ps

module imasb_master
    import imasb_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // request side
    output logic rd_en,
    output logic wr_en,
    output logic [15:0] addr,
    output logic [15:0] wr_data,
    // answer side
    input wire logic ack,
    input wire logic [15:0] rd_data,
    input wire logic addr_fault,
    input wire logic write_refused
);

    initial begin
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 16'h0000;
        wr_data = 16'h0000;
    end

    // one request, then a bounded wait for the acknowledge pulse
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic [15:0] d, output logic [15:0] rdat,
                          output logic flt, output logic refw,
                          output logic got);
        int i;
        got = 1'b0;
        rdat = 16'h0000;
        flt = 1'b0;
        refw = 1'b0;
        @(posedge ref_clk);
        rd_en <= ~wr;
        wr_en <= wr;
        addr <= a;
        wr_data <= d;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        // released lines do not keep the last value
        addr <= ~a;
        wr_data <= ~d;
        for (i = 0; i < 4 && !got; i++) begin
            @(posedge ref_clk);
            if (ack === 1'b1) begin
                got = 1'b1;
                rdat = rd_data;
                flt = addr_fault;
                refw = write_refused;
            end
        end
    endtask : access

endmodule : imasb_master

// ### verification/io_module_alarm_status_bank_tb.sv
// self-checking bench of the alarm status bank with a polling master model
// assumes imasb_pkg, imasb_bank and imasb_master are compiled first
`timescale 1ns/1ps

module io_module_alarm_status_bank_tb
    import imasb_pkg::*;
;
    logic ref_clk;
    logic rst;
    logic rd_en;
    logic wr_en;
    logic [15:0] addr;
    logic [15:0] wr_data;
    logic ack;
    logic [15:0] rd_data;
    logic addr_fault;
    logic write_refused;
    logic [1:0][6:0][15:0] raw;
    logic [1:0][6:0][15:0] valid;
    int num_errors;
    int checks_done;
    int seed_dummy;

    imasb_master i_imasb_master (
        .ref_clk(ref_clk), .rst(rst), .rd_en(rd_en), .wr_en(wr_en),
        .addr(addr), .wr_data(wr_data), .ack(ack), .rd_data(rd_data),
        .addr_fault(addr_fault), .write_refused(write_refused)
    );

    // alarm sources sit at their documented bit of the raw word
    imasb_bank i_imasb_bank (
        .ref_clk(ref_clk), .rst(rst), .rd_en(rd_en), .wr_en(wr_en),
        .addr(addr), .wr_data(wr_data), .ack(ack), .rd_data(rd_data),
        .addr_fault(addr_fault), .write_refused(write_refused),
        .counter_overrun({raw[1][0][10:8], raw[0][0][10:8]}),
        .temp_overrun({raw[1][0][13:11], raw[0][0][13:11]}),
        .user_input_alarm({raw[1][1][5:0], raw[0][1][5:0]}),
        .cradle_position_mismatch({raw[1][2][0], raw[0][2][0]}),
        .removal_overdue({raw[1][2][1], raw[0][2][1]}),
        .operation_limit({raw[1][2][2], raw[0][2][2]}),
        .cradle_life_low({raw[1][2][3], raw[0][2][3]}),
        .new_trip_unit({raw[1][2][4], raw[0][2][4]}),
        .drawer_position_mismatch({raw[1][2][8], raw[0][2][8]}),
        .contactor_not_closed({raw[1][4][0], raw[0][4][0]}),
        .contactor_not_opened({raw[1][4][1], raw[0][4][1]}),
        .dual_setting_mismatch({raw[1][4][3], raw[0][4][3]}),
        .earth_leakage_trip_contact({raw[1][5][0], raw[0][5][0]}),
        .control_voltage_contact({raw[1][5][1], raw[0][5][1]}),
        .surge_status_contact({raw[1][5][2], raw[0][5][2]}),
        .surge_failure_contact({raw[1][5][3], raw[0][5][3]}),
        .switch_position_indication_contact({raw[1][5][4], raw[0][5][4]}),
        .fuse_blown_contact({raw[1][5][5], raw[0][5][5]}),
        .emergency_stop({raw[1][5][6], raw[0][5][6]}),
        .panel_temp_contact({raw[1][5][7], raw[0][5][7]}),
        .ventilation_contact({raw[1][5][8], raw[0][5][8]}),
        .door_contact({raw[1][5][9], raw[0][5][9]}),
        .hw_critical({raw[1][6][0], raw[0][6][0]}),
        .fw_critical({raw[1][6][1], raw[0][6][1]}),
        .hw_noncritical({raw[1][6][2], raw[0][6][2]}),
        .fw_noncritical({raw[1][6][3], raw[0][6][3]}),
        .bit_valid(valid)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // defined bits of each alarm word
    function automatic logic [15:0] word_mask(input int w);
        case (w)
            0: word_mask = 16'h3F00;
            1: word_mask = 16'h003F;
            2: word_mask = 16'h011F;
            3: word_mask = 16'h0000;
            4: word_mask = 16'h000B;
            5: word_mask = 16'h03FF;
            default: word_mask = 16'h000F;
        endcase
    endfunction : word_mask

    // quality address of word w; the status word follows it
    function automatic logic [15:0] qual_addr(input int i, input int w);
        logic [15:0] b;
        b = (i == 0) ? 16'h3989 : 16'h4541;
        qual_addr = b + 16'h000A + 16'(2 * w);
    endfunction : qual_addr

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic wr, input logic [15:0] a,
                          input logic [15:0] exp, input logic exp_flt);
        logic [15:0] d;
        logic f;
        logic r;
        logic g;
        i_imasb_master.access(wr, a, 16'($urandom), d, f, r, g);
        check(16'(g), 16'h0001, "acknowledge");
        if (g !== 1'b1) begin
            complete_run();
        end
        check(d, exp, "read data");
        check(16'(f), 16'(exp_flt), "address fault");
        check(16'(r), 16'(wr), "write refusal");
    endtask : rd_chk

    task automatic check_word(input int i, input int w);
        rd_chk(1'b0, qual_addr(i, w), valid[i][w] & word_mask(w), 1'b0);
        rd_chk(1'b0, qual_addr(i, w) + 16'h0001, raw[i][w] & word_mask(w),
               1'b0);
    endtask : check_word

    task automatic check_inst(input int i);
        check_word(i, 0);
        check_word(i, 1);
        check_word(i, 2);
        check_word(i, 3);
        check_word(i, 4);
        check_word(i, 5);
        check_word(i, 6);
    endtask : check_inst

    // new inputs, then enough edges for the stored words to follow
    task automatic load(input int n);
        logic [1:0][6:0][15:0] nr;
        logic [1:0][6:0][15:0] nv;
        for (int k = 0; k < 14; k++) begin
            nr[k / 7][k % 7] = (n == 0) ? 16'hFFFF : 16'($urandom);
            nv[k / 7][k % 7] = (n == 1) ? 16'hFFFF : 16'($urandom);
        end
        @(posedge ref_clk);
        raw <= (n == 1) ? '0 : nr;
        valid <= (n == 0) ? '0 : nv;
        repeat (3) @(posedge ref_clk);
    endtask : load

    logic [15:0] rsv_addr [4] = '{16'h398D, 16'h3992, 16'h39A1, 16'h4559};
    logic [15:0] bad_addr [5] = '{16'h3988, 16'h39A7, 16'h4540, 16'h455F,
                                  16'hFFFF};

    initial begin
        rst = 1'b1;
        raw = '0;
        valid = '0;
        num_errors = 0;
        checks_done = 0;
        seed_dummy = $urandom(25);
        repeat (5) @(posedge ref_clk);
        check(16'(ack), 16'h0000, "ack in reset");
        check(rd_data, 16'h0000, "read data in reset");
        rst <= 1'b0;
        for (int n = 0; n < 12; n++) begin
            load(n);
            check_inst(0);
            check_inst(1);
        end
        // writes are refused and leave every stored word as it was
        load(5);
        for (int k = 0; k < 28; k++) begin
            rd_chk(1'b1, qual_addr(k / 14, (k % 14) / 2) + 16'(k % 2),
                   16'h0000, 1'b0);
        end
        rd_chk(1'b1, 16'h0100, 16'h0000, 1'b1);
        check_inst(0);
        check_inst(1);
        // reserved places read zero, places outside both windows fault
        foreach (rsv_addr[k]) begin
            rd_chk(1'b0, rsv_addr[k], 16'h0000, 1'b0);
        end
        foreach (bad_addr[k]) begin
            rd_chk(1'b0, bad_addr[k], 16'h0000, 1'b1);
        end
        complete_run();
    end

endmodule : io_module_alarm_status_bank_tb
